// File: rtl/bbdr_pkg.sv
`default_nettype none
package bbdr_pkg;
  // Rate figures in bits (or symbols) per second.
  localparam longint SERIAL_MAX_BPS = 64'd50000000;
  localparam longint SYMBOL_MAX_SPS = 64'd50000000;
  localparam longint FIR16_MAX_BPS_PER_BIT = 64'd50000000;
  localparam int FIR_LOG2_16 = 0;
  localparam int FIR_LOG2_32 = 1;
  localparam int FIR_LOG2_64 = 2;
  localparam int MAX_BITS_PER_SYM = 8;
  localparam logic [3:0] BPS_MAX = 4'h8;
  // Pattern memory geometry and byte layout.
  localparam int PM_ADDR_W = 10;
  localparam int PM_DEPTH = 1024;
  localparam int PM_BIT_DATA = 0;
  localparam int PM_BIT_RSV1 = 1;
  localparam int PM_BIT_BURST = 2;
  localparam int PM_BIT_RSV3 = 3;
  localparam int PM_BIT_RSV4 = 4;
  localparam int PM_BIT_RSV5 = 5;
  localparam int PM_BIT_SYNC = 6;
  localparam int PM_BIT_RESTART = 7;
  localparam logic [7:0] PM_RESET_BYTE = 8'h10;
  // Data source selection.
  localparam logic [1:0] SRC_STREAM = 2'h0;
  localparam logic [1:0] SRC_USER_FILE = 2'h1;
  localparam logic [1:0] SRC_PATTERN = 2'h2;
  // Format selection.
  localparam logic [1:0] FMT_CUSTOM = 2'h0;
  localparam logic [1:0] FMT_TDMA = 2'h1;
  localparam logic [1:0] FMT_OTHER = 2'h2;
  localparam logic [3:0] SYNC_BASE_WIDTH = 4'h1;
  typedef enum logic [3:0] {
    BBDR_IDLE = 4'b0001,
    BBDR_EVAL = 4'b0010,
    BBDR_SERIAL = 4'b0100,
    BBDR_PARALLEL = 4'b1000
  } bbdr_state_t;
endpackage : bbdr_pkg
`default_nettype wire

// File: rtl/bbdr_pattern_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Flip-flop pattern memory with one write port and one registered read port.
module bbdr_pattern_mem
  import bbdr_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic wr_en, // Write strobe.
  input wire logic [PM_ADDR_W-1:0] wr_addr, // Write address.
  input wire logic [7:0] wr_byte, // Write data.
  input wire logic [PM_ADDR_W-1:0] rd_addr, // Read address.
  output logic [7:0] rd_byte // Read data, one cycle after address.
);
  logic [7:0] mem_q [PM_DEPTH];
  logic [7:0] mem_d [PM_DEPTH];
  logic [7:0] rd_d;
  logic [7:0] rd_q;

  always_comb
  begin
    for (int i = 0; i < PM_DEPTH; i++)
    begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en)
    begin
      mem_d[wr_addr] = wr_byte;
    end
    rd_d = mem_q[rd_addr];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < PM_DEPTH; i++)
      begin
        mem_q[i] <= PM_RESET_BYTE;
      end
      rd_q <= PM_RESET_BYTE;
    end
    else
    begin
      mem_q <= mem_d;
      rd_q <= rd_d;
    end
  end

  assign rd_byte = rd_q;
endmodule : bbdr_pattern_mem
`default_nettype wire

// File: rtl/bbdr_data_path.sv
`timescale 1ns/100ps
`default_nettype none
module bbdr_data_path
  import bbdr_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic run, // Enables data output.
  input wire logic [1:0] data_src, // Stream, user file or pattern file.
  input wire logic [1:0] fmt_sel, // Custom, TDMA or other format.
  input wire logic tdma_unframed, // TDMA unframed data selection.
  input wire logic [31:0] sym_rate_sps, // Selected symbol rate.
  input wire logic [3:0] bits_per_sym, // Bits per symbol, 1 to 8.
  input wire logic [1:0] fir_log2, // FIR width 16, 32 or 64 as 0, 1, 2.
  input wire logic pm_wr_en, // Pattern memory write strobe.
  input wire logic [PM_ADDR_W-1:0] pm_wr_addr, // Pattern memory write address.
  input wire logic [7:0] pm_wr_byte, // Pattern memory write byte.
  input wire logic step, // One data step, bit or symbol.
  input wire logic [7:0] stream_sym, // Incoming stream symbol, low bits used.
  output logic stream_ready, // Stream step in serial or parallel state with no re-evaluation pending; run is not checked.
  output logic [7:0] out_sym, // Output bits of the current step.
  output logic out_valid, // Output step valid.
  output logic rf_burst, // RF on when high.
  output logic sync_pulse, // Sync pulse output.
  output logic parallel_mode, // High in parallel symbol processing.
  output logic rate_error, // Requested rate outside limits.
  output logic pattern_refused // Pattern playback not allowed in format.
);
  bbdr_state_t st_q, st_d;
  logic [PM_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] sym_q, sym_d;
  logic valid_q, valid_d, burst_q, burst_d;
  logic [3:0] sync_cnt_q, sync_cnt_d;
  logic [31:0] rate_q, rate_d;
  logic [3:0] bps_q, bps_d;
  logic err_q, err_d, refuse_q, refuse_d;
  logic [7:0] pm_byte;
  logic [PM_ADDR_W-1:0] rd_addr;
  logic [63:0] bit_rate, bit_limit;
  logic pattern_ok, cfg_change, want_par;
  logic rate_bad, mode_stale;

  // Limit of the bit rate for the selected filter width.
  function automatic logic [63:0] rate_limit(input logic [3:0] bps, input logic [1:0] fl);
    rate_limit = (FIR16_MAX_BPS_PER_BIT * 64'(bps)) >> fl;
  endfunction : rate_limit

  // Bits above the symbol width are not payload, so they never reach the output.
  function automatic logic [7:0] sym_mask(input logic [3:0] bps);
    sym_mask = 8'hFF >> (4'h8 - bps);
  endfunction : sym_mask

  bbdr_pattern_mem u_mem (
    .clk(clk),
    .rstn(rstn),
    .wr_en(pm_wr_en),
    .wr_addr(pm_wr_addr),
    .wr_byte(pm_wr_byte),
    .rd_addr(rd_addr),
    .rd_byte(pm_byte)
  );

  assign bit_rate = 64'(sym_rate_sps) * 64'(bits_per_sym);
  assign bit_limit = rate_limit(bits_per_sym, fir_log2);
  assign pattern_ok = (fmt_sel == FMT_CUSTOM) || ((fmt_sel == FMT_TDMA) && tdma_unframed);
  assign want_par = (data_src == SRC_STREAM) && (fmt_sel == FMT_CUSTOM)
    && (bit_rate > SERIAL_MAX_BPS) && (bits_per_sym > 4'h1);
  assign rate_bad = (64'(sym_rate_sps) > SYMBOL_MAX_SPS) || (bit_rate > bit_limit)
    || (bits_per_sym == 4'h0) || (bits_per_sym > BPS_MAX) || (fir_log2 > 2'h2);
  // A source, format or filter change while running would otherwise leave a stale mode
  // in force, such as parallel processing of a pattern file, so it forces a new evaluation.
  assign mode_stale = (want_par != (st_q == BBDR_PARALLEL)) || rate_bad
    || ((data_src == SRC_PATTERN) && !pattern_ok);
  assign cfg_change = (sym_rate_sps != rate_q) || (bits_per_sym != bps_q)
    || mode_stale;
  // Current address drives the read, so the registered byte follows an address change one cycle later.
  assign rd_addr = addr_q;

  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    sym_d = sym_q;
    valid_d = 1'b0;
    burst_d = burst_q;
    sync_cnt_d = (sync_cnt_q != 4'h0) ? sync_cnt_q - 4'h1 : 4'h0;
    rate_d = rate_q;
    bps_d = bps_q;
    err_d = err_q;
    refuse_d = refuse_q;
    case (st_q)
      BBDR_IDLE:
      begin
        // Error and refusal flags keep their last verdict in idle so a stopped run shows why.
        burst_d = 1'b0;
        addr_d = '0;
        if (run)
        begin
          st_d = BBDR_EVAL;
        end
      end
      BBDR_EVAL:
      begin
        rate_d = sym_rate_sps;
        bps_d = bits_per_sym;
        err_d = rate_bad;
        refuse_d = (data_src == SRC_PATTERN) && !pattern_ok;
        addr_d = '0;
        if (!run)
        begin
          st_d = BBDR_IDLE;
        end
        else if (!err_d && !refuse_d)
        begin
          st_d = want_par ? BBDR_PARALLEL : BBDR_SERIAL;
        end
      end
      BBDR_SERIAL, BBDR_PARALLEL:
      begin
        if (!run)
        begin
          st_d = BBDR_IDLE;
        end
        else if (cfg_change)
        begin
          st_d = BBDR_EVAL;
        end
        else if (step)
        begin
          valid_d = 1'b1;
          if (data_src == SRC_STREAM)
          begin
            // Serial steps carry one bit; parallel steps a whole symbol.
            sym_d = (st_q == BBDR_PARALLEL) ? (stream_sym & sym_mask(bits_per_sym))
              : {7'h00, stream_sym[0]};
            burst_d = 1'b1;
            if (sync_cnt_q == 4'h0)
            begin
              sync_cnt_d = (st_q == BBDR_PARALLEL) ? bits_per_sym : SYNC_BASE_WIDTH;
            end
          end
          else
          begin
            // Reserved bits of the byte are ignored on purpose.
            sym_d = {7'h00, pm_byte[PM_BIT_DATA]};
            burst_d = pm_byte[PM_BIT_BURST];
            if (pm_byte[PM_BIT_SYNC])
            begin
              sync_cnt_d = SYNC_BASE_WIDTH;
            end
            addr_d = pm_byte[PM_BIT_RESTART] ? '0 : addr_q + 1'b1;
          end
        end
      end
      default:
      begin
        st_d = BBDR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= BBDR_IDLE;
      addr_q <= '0;
      sym_q <= 8'h00;
      valid_q <= 1'b0;
      burst_q <= 1'b0;
      sync_cnt_q <= 4'h0;
      rate_q <= 32'h0000_0000;
      bps_q <= 4'h0;
      err_q <= 1'b0;
      refuse_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      sym_q <= sym_d;
      valid_q <= valid_d;
      burst_q <= burst_d;
      sync_cnt_q <= sync_cnt_d;
      rate_q <= rate_d;
      bps_q <= bps_d;
      err_q <= err_d;
      refuse_q <= refuse_d;
    end
  end

  // Ready is combinational: a step refused for a pending re-evaluation shows ready low at once.
  assign stream_ready = step && (data_src == SRC_STREAM) && !cfg_change
    && ((st_q == BBDR_SERIAL) || (st_q == BBDR_PARALLEL));
  assign out_sym = sym_q;
  assign out_valid = valid_q;
  assign rf_burst = burst_q;
  assign sync_pulse = (sync_cnt_q != 4'h0);
  assign parallel_mode = (st_q == BBDR_PARALLEL);
  assign rate_error = err_q;
  assign pattern_refused = refuse_q;
endmodule : bbdr_data_path
`default_nettype wire

// File: testbench/bbdr_data_path_sva.sv
`timescale 1ns/100ps
`default_nettype none
module bbdr_data_path_sva
  import bbdr_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rstn, // Reset.
  input wire logic step, // Step.
  input wire logic [1:0] data_src, // Source.
  input wire logic [1:0] fmt_sel, // Format.
  input wire logic [31:0] sym_rate_sps, // Rate.
  input wire logic [3:0] bits_per_sym, // Width.
  input wire logic out_valid, // Valid.
  input wire logic sync_pulse, // Sync.
  input wire logic parallel_mode, // Mode.
  input wire logic rate_error, // Error.
  input wire logic pattern_refused // Refusal.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_STEP_ANSWER: assert property (out_valid |-> $past(step))
    else $error("output without step");
  AST_PAR_ENTRY: assert property ($rose(parallel_mode) |->
    $past(fmt_sel) == FMT_CUSTOM && $past(data_src) == SRC_STREAM) else $error("bad entry");
  AST_PAR_RATE: assert property ($rose(parallel_mode) |->
    64'($past(sym_rate_sps)) * $past(bits_per_sym) > SERIAL_MAX_BPS
    && $past(sym_rate_sps) <= SYMBOL_MAX_SPS) else $error("bad parallel rate");
  AST_ERR_HOLDS: assert property (rate_error |-> !parallel_mode && !out_valid)
    else $error("error not holding");
  AST_REFUSE: assert property (pattern_refused |-> !out_valid && !parallel_mode)
    else $error("refused but running");
  AST_SYNC_SER: assert property ($rose(sync_pulse) && !parallel_mode && !step |=> !sync_pulse)
    else $error("serial sync too wide");
  AST_SYNC_PAR: assert property (($rose(sync_pulse) && parallel_mode
    && bits_per_sym == 4'h2 && !step) ##1 !step |-> sync_pulse ##1 !sync_pulse)
    else $error("parallel sync width");
  AST_RATE_CHANGE: assert property (step && sym_rate_sps != $past(sym_rate_sps) |=> !out_valid)
    else $error("step taken on rate change");
endmodule : bbdr_data_path_sva
`default_nettype wire

// File: testbench/bbdr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module bbdr_ctrl_model
  import bbdr_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic start, // Begin download.
  output logic pm_wr_en, // Write strobe.
  output logic [PM_ADDR_W-1:0] pm_wr_addr, // Address.
  output logic [7:0] pm_wr_byte, // Byte.
  output logic done // Download over.
);
  // Restart, sync, burst and data bits of each byte.
  localparam logic [2:0][3:0] CTRL = {4'hB, 4'h0, 4'h7};
  initial
  begin
    {pm_wr_en, pm_wr_addr, pm_wr_byte, done} = '0;
    @(posedge start);
    for (int a = 0; a < 3; a++)
    begin
      @(negedge clk);
      pm_wr_en = 1'h1;
      pm_wr_addr = PM_ADDR_W'(a);
      pm_wr_byte = {CTRL[a][3:2], 3'h2, CTRL[a][1], 1'h0, CTRL[a][0]};
    end
    @(negedge clk);
    pm_wr_en = 1'h0;
    // Released lines show the inverse so stale values are never trusted.
    pm_wr_addr = ~pm_wr_addr;
    pm_wr_byte = ~pm_wr_byte;
    done = 1'h1;
  end
endmodule : bbdr_ctrl_model
`default_nettype wire

// File: testbench/baseband_data_rate_path_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module baseband_data_rate_path_tb_top import bbdr_pkg::*;;
  typedef struct {
    logic [1:0] src, fmt;
    logic unf;
    logic [31:0] sps;
    logic [3:0] bps;
    logic [1:0] fir;
    logic [2:0] exp;
    logic [7:0] sym;
  } bbdr_row_t;
  bbdr_row_t r;
  bbdr_row_t rows [12] = '{
    '{2'h0, 2'h0, 1'h0, 32'h989680, 4'h1, 2'h0, 3'h0, 8'h01},
    '{2'h0, 2'h0, 1'h0, 32'h2625A00, 4'h2, 2'h0, 3'h4, 8'h01},
    '{2'h0, 2'h0, 1'h0, 32'h2625A00, 4'h2, 2'h1, 3'h2, 8'h01},
    '{2'h0, 2'h0, 1'h0, 32'h2FAF080, 4'h8, 2'h0, 3'h4, 8'hA5},
    '{2'h0, 2'h0, 1'h0, 32'h3938700, 4'h1, 2'h0, 3'h2, 8'h01},
    '{2'h0, 2'h1, 1'h0, 32'h2625A00, 4'h2, 2'h0, 3'h0, 8'h01},
    '{2'h2, 2'h2, 1'h0, 32'h989680, 4'h1, 2'h0, 3'h1, 8'h01},
    '{2'h2, 2'h1, 1'h0, 32'h989680, 4'h1, 2'h0, 3'h1, 8'h01},
    '{2'h2, 2'h1, 1'h1, 32'h2625A00, 4'h2, 2'h0, 3'h0, 8'h01},
    '{2'h0, 2'h0, 1'h0, 32'h989680, 4'h4, 2'h2, 3'h0, 8'h01},
    '{2'h0, 2'h0, 1'h0, 32'h989680, 4'h1, 2'h3, 3'h2, 8'h01},
    '{2'h1, 2'h1, 1'h0, 32'h989680, 4'h1, 2'h0, 3'h0, 8'h01}};
  logic [3:0][2:0] pexp = {3'h7, 3'h3, 3'h0, 3'h7};
  logic clk = 1'h0, rstn = 1'h0, run = 1'h0, tdma_unframed = 1'h0, step = 1'h0, load = 1'h0;
  logic [1:0] data_src = 2'h0, fmt_sel = 2'h0, fir_log2 = 2'h0;
  logic [31:0] sym_rate_sps = 32'h0;
  logic [3:0] bits_per_sym = 4'h1;
  logic [7:0] stream_sym = 8'h0;
  logic rdy = 1'h0;
  wire logic pm_wr_en, loaded, stream_ready, out_valid, rf_burst, sync_pulse, parallel_mode;
  wire logic rate_error, pattern_refused;
  wire logic [PM_ADDR_W-1:0] pm_wr_addr;
  wire logic [7:0] pm_wr_byte, out_sym;
  int fails = 0, check_count = 0;
  bbdr_ctrl_model ctrl (.clk, .start(load), .pm_wr_en, .pm_wr_addr, .pm_wr_byte, .done(loaded));
  bbdr_data_path uut (.clk, .rstn, .run, .data_src, .fmt_sel, .tdma_unframed, .sym_rate_sps,
    .bits_per_sym, .fir_log2, .pm_wr_en, .pm_wr_addr, .pm_wr_byte, .step, .stream_sym,
    .stream_ready, .out_sym, .out_valid, .rf_burst, .sync_pulse, .parallel_mode, .rate_error,
    .pattern_refused);
  always #5 clk = ~clk;
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic cfg(input bbdr_row_t c);
    @(negedge clk);
    {data_src, fmt_sel, tdma_unframed, sym_rate_sps} = {c.src, c.fmt, c.unf, c.sps};
    {bits_per_sym, fir_log2, run} = {c.bps, c.fir, 1'h1};
    repeat (4) @(negedge clk);
  endtask : cfg
  task automatic pulse(input logic [7:0] s);
    @(negedge clk);
    step = 1'h1;
    stream_sym = s;
    #1;
    rdy = stream_ready;
    @(negedge clk);
    step = 1'h0;
  endtask : pulse
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    load = 1'h1;
    repeat (6) @(negedge clk);
    check("load", 8'h01, {7'h0, loaded});
    foreach (rows[i])
    begin
      cfg(rows[i]);
      check("mode", {5'h0, rows[i].exp}, {5'h0, parallel_mode, rate_error, pattern_refused});
      pulse(8'hA5);
      check("ready", {7'h0, rows[i].exp[1:0] == 2'h0 && rows[i].src == SRC_STREAM}, {7'h0, rdy});
      check("valid", {7'h0, rows[i].exp[1:0] == 2'h0}, {7'h0, out_valid});
      if (rows[i].exp[1:0] == 2'h0)
        check("sym", rows[i].sym, out_sym);
      // Run stays up three more cycles; the sync count keeps running down in idle as well.
      repeat (3) @(negedge clk);
      run = 1'h0;
      $display("row %0d done", i);
    end
    r = rows[0];
    r.src = SRC_PATTERN;
    cfg(r);
    for (int k = 0; k < 4; k++)
    begin
      pulse(8'h00);
      check("pattern", {5'h0, pexp[k]}, {5'h0, sync_pulse, rf_burst, out_sym[0]});
    end
    run = 1'h0;
    $display("pattern test done");
    cfg(rows[0]);
    step = 1'h1;
    sym_rate_sps = 32'h1312D00;
    #1;
    check("stale ready", 8'h00, {7'h0, stream_ready});
    @(negedge clk);
    step = 1'h0;
    check("stale step", 8'h00, {7'h0, out_valid});
    repeat (4) @(negedge clk);
    pulse(8'h01);
    check("fresh step", 8'h01, {7'h0, out_valid});
    cfg(rows[1]);
    check("par before", 8'h01, {7'h0, parallel_mode});
    data_src = SRC_PATTERN;
    repeat (2) @(negedge clk);
    check("src change", 8'h00, {7'h0, parallel_mode});
    $display("rate change test done");
    pulse(8'h01);
    rstn = 1'h0;
    #1;
    check("reset", 8'h00, {2'h0, out_valid, rf_burst, sync_pulse, parallel_mode, rate_error,
      pattern_refused});
    check("reset sym", 8'h00, out_sym);
    run = 1'h0;
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    repeat (2) @(negedge clk);
    $display("reset test done");
    report_and_stop();
  end
  initial
  begin
    #100us;
    fails++;
    report_and_stop();
  end
endmodule : baseband_data_rate_path_tb_top
bind bbdr_data_path bbdr_data_path_sva chk (.clk, .rstn, .step, .data_src, .fmt_sel,
  .sym_rate_sps, .bits_per_sym, .out_valid, .sync_pulse, .parallel_mode, .rate_error,
  .pattern_refused);
`default_nettype wire
